// *** include/pirq_cfg.svh ***
// Register offsets, field positions, reset values and masks of the peripheral flag and enable bank
`ifndef PIRQ_CFG_SVH
`define PIRQ_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (register index on the plain port)
// ----------------------------------------------------------------------------
`define PIRQ_OFF_FLAGS_TWO    4'h0
`define PIRQ_OFF_FLAGS_THREE  4'h1
`define PIRQ_OFF_ENABLES_ONE  4'h2
`define PIRQ_OFF_ENABLES_TWO  4'h3
`define PIRQ_OFF_CONTROL      4'h4

// ----------------------------------------------------------------------------
// Field positions, flags two / enables two
// ----------------------------------------------------------------------------
`define PIRQ_B_OSC_FAIL       7
`define PIRQ_B_CMP_CHANGE     6
`define PIRQ_B_TWO_UNIMPL     5
`define PIRQ_B_NVM_DONE       4
`define PIRQ_B_BUS_COLL_A     3
`define PIRQ_B_VOLTAGE        2
`define PIRQ_B_TIMER3_OVF     1
`define PIRQ_B_CAPCOMP_B      0

// ----------------------------------------------------------------------------
// Field positions, flags three
// ----------------------------------------------------------------------------
`define PIRQ_B_SYNC_SERIAL_B  7
`define PIRQ_B_BUS_COLL_B     6
`define PIRQ_B_SERIAL_B_RX    5
`define PIRQ_B_SERIAL_B_TX    4
`define PIRQ_B_TIMER4_MATCH   3
`define PIRQ_B_CAPCOMP_E      2

// ----------------------------------------------------------------------------
// Field positions, control register
// ----------------------------------------------------------------------------
`define PIRQ_B_PERIPH_GLOBAL  0
`define PIRQ_B_PRIO_LEVELS    1

// ----------------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------------
`define PIRQ_RST_BYTE         8'h00
`define PIRQ_RST_CTRL         2'h0
`define PIRQ_MASK_TWO         8'hdf
`define PIRQ_MASK_THREE_WR    8'hcf
`define PIRQ_MASK_CTRL        8'h03

`endif

// *** include/pirq_pkg.sv ***
// Types of the peripheral flag and enable bank
package pirq_pkg;

    typedef struct packed {
        logic [7:0] flags_two;
        logic [7:0] flags_three;
        logic [7:0] en_one;
        logic [7:0] en_two;
        logic [1:0] ctrl;
        logic [7:0] rd_data;
        logic       irq;
    } pirq_state_t;

    typedef struct packed {
        logic sync_q1;
        logic sync_q2;
        logic level_d;
        logic change;
    } pirq_edge_state_t;

endpackage

// *** include/pirq_evt_if.sv ***
// Event carrier between the comparator edge detector and the flag bank
`timescale 1ns/1ps
interface pirq_evt_if;
    logic cmp_change;

    modport src (output cmp_change);
    modport dst (input  cmp_change);
endinterface

// *** verilog/pirq_cmp_edge.sv ***
// Comparator output synchroniser and change detector
`timescale 1ns/1ps
module pirq_cmp_edge (
    input  wire logic   clock_i,
    input  wire logic   sys_rst_i,
    input  wire logic   ce_i,
    input  wire logic   comparator_level_i,
    pirq_evt_if.src     evt
);

    pirq_pkg::pirq_edge_state_t state_reg;
    pirq_pkg::pirq_edge_state_t state_next;

    // ------------------------------------------------------------------------
    // Two flops, then compare the settled copy against its last value
    // ------------------------------------------------------------------------
    always_comb begin
        state_next         = state_reg;
        state_next.sync_q1 = comparator_level_i;
        state_next.sync_q2 = state_reg.sync_q1;
        state_next.level_d = state_reg.sync_q2;
        state_next.change  = state_reg.sync_q2 ^ state_reg.level_d;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_reg <= '0;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    // Held for one enabled cycle only, so a frozen clock enable cannot double-count
    assign evt.cmp_change = state_reg.change & ce_i;

endmodule

// *** verilog/pirq_bank.sv ***
// Peripheral interrupt flag and enable bank with request gating toward the core
`timescale 1ns/1ps
`include "pirq_cfg.svh"

// Summary of operation
// - Oscillator failure event sets flags two bit 7; held until software clears.
// - Any comparator output change sets flags two bit 6.
// - Bit 5 of flags two and enables two reads zero, ignores writes.
// - Nonvolatile write completion sets flags two bit 4.
// - First serial bus collision as master sets flags two bit 3.
// - Low-voltage detect sets flags two bit 2.
// - Timer three overflow sets flags two bit 1.
// - Capture or compare unit B sets bit 0; ignored in PWM mode.
// - Second sync serial transfer completion sets flags three bit 7.
// - Second sync serial bus collision sets flags three bit 6.
// - Flags three bit 5 mirrors receive buffer full; read-only.
// - Flags three bit 4 mirrors transmit buffer empty; read-only.
// - Timer four period match sets flags three bit 3.
// - Capture/compare units E, D, C set bits 2..0; ignored in PWM mode.
// - Event flags stay set until software writes zero; software clears them.
// - Without priority levels, requests need the peripheral global enable.
// - Enables one gates the eight flags-one sources bit by bit.
// - Enables two gates flags two bit by bit; one enables.
// - Flags set on events regardless of enables, allowing polling.
module pirq_bank #(
    parameter int ADDR_W = 4
) (
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    input  wire logic              ce_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [7:0]        reg_rdata_o,
    input  wire logic              osc_fail_evt_i,
    input  wire logic              comparator_level_i,
    input  wire logic              nvm_write_done_evt_i,
    input  wire logic              bus_collision_a_evt_i,
    input  wire logic              voltage_low_evt_i,
    input  wire logic              timer3_overflow_evt_i,
    input  wire logic              sync_serial_b_evt_i,
    input  wire logic              bus_collision_b_evt_i,
    input  wire logic              serial_b_rx_full_i,
    input  wire logic              serial_b_tx_empty_i,
    input  wire logic              timer4_match_evt_i,
    input  wire logic [3:0]        capcomp_evt_i,
    input  wire logic [3:0]        capcomp_pwm_mode_i,
    input  wire logic [7:0]        flags_one_i,
    input  wire logic [7:0]        enables_three_i,
    output logic                   peripheral_irq_o
);

    // ------------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------------
    generate
        if (ADDR_W < 3) begin : g_bad_addr
            $error("ADDR_W must be at least 3 to reach the control register");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Comparator change detection
    // ------------------------------------------------------------------------
    pirq_evt_if cmp_evt ();

    pirq_cmp_edge u_cmp_edge (
        .clock_i            (clock_i),
        .sys_rst_i          (sys_rst_i),
        .ce_i               (ce_i),
        .comparator_level_i (comparator_level_i),
        .evt                (cmp_evt.src)
    );

    // ------------------------------------------------------------------------
    // Event vectors
    // ------------------------------------------------------------------------
    logic [3:0] cc_live;
    logic [7:0] evt_two;
    logic [7:0] evt_three;

    // Capture/compare events are dropped in PWM mode; the unit then owns the flag bit as unused
    assign cc_live = capcomp_evt_i & ~capcomp_pwm_mode_i;

    assign evt_two = {osc_fail_evt_i,
                      cmp_evt.cmp_change,
                      1'b0,
                      nvm_write_done_evt_i,
                      bus_collision_a_evt_i,
                      voltage_low_evt_i,
                      timer3_overflow_evt_i,
                      cc_live[0]};

    assign evt_three = {sync_serial_b_evt_i,
                        bus_collision_b_evt_i,
                        2'b00,
                        timer4_match_evt_i,
                        cc_live[3:1]};

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    pirq_pkg::pirq_state_t state_reg;
    pirq_pkg::pirq_state_t state_next;

    logic [3:0] addr_idx;
    logic       wr_two;
    logic       wr_three;
    logic       wr_en_one;
    logic       wr_en_two;
    logic       wr_ctrl;
    logic [7:0] req_vec_one;
    logic [7:0] req_vec_two;
    logic [7:0] req_vec_three;
    logic       any_req;
    logic       gate_open;

    // Upper address bits must be zero; a wide bus never aliases onto the map
    assign addr_idx  = (reg_addr_i >> 4) == '0 ? 4'(reg_addr_i) : 4'hf;
    assign wr_two    = reg_wr_i && (addr_idx == `PIRQ_OFF_FLAGS_TWO);
    assign wr_three  = reg_wr_i && (addr_idx == `PIRQ_OFF_FLAGS_THREE);
    assign wr_en_one = reg_wr_i && (addr_idx == `PIRQ_OFF_ENABLES_ONE);
    assign wr_en_two = reg_wr_i && (addr_idx == `PIRQ_OFF_ENABLES_TWO);
    assign wr_ctrl   = reg_wr_i && (addr_idx == `PIRQ_OFF_CONTROL);

    // ------------------------------------------------------------------------
    // Request gating, computed on the registered state and the live flags_one_i and enables_three_i inputs
    // ------------------------------------------------------------------------
    assign req_vec_one   = flags_one_i & state_reg.en_one;
    assign req_vec_two   = state_reg.flags_two & state_reg.en_two;
    assign req_vec_three = state_reg.flags_three & enables_three_i;
    assign any_req       = |{req_vec_one, req_vec_two, req_vec_three};
    // With priority levels on, the core's own priority logic decides; this gate stays open
    assign gate_open     = state_reg.ctrl[`PIRQ_B_PERIPH_GLOBAL] |
                           state_reg.ctrl[`PIRQ_B_PRIO_LEVELS];

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // Per-bit flag update: event set wins over a software clear in the same cycle
        for (int b = 0; b < 8; b++) begin
            if (wr_two) begin
                state_next.flags_two[b] = reg_wdata_i[b] | evt_two[b];
            end else begin
                state_next.flags_two[b] = state_reg.flags_two[b] | evt_two[b];
            end
            if (wr_three) begin
                state_next.flags_three[b] = reg_wdata_i[b] | evt_three[b];
            end else begin
                state_next.flags_three[b] = state_reg.flags_three[b] | evt_three[b];
            end
        end
        state_next.flags_two   = state_next.flags_two & `PIRQ_MASK_TWO;
        state_next.flags_three = state_next.flags_three & `PIRQ_MASK_THREE_WR;
        // Buffer status bits follow the serial port and ignore writes
        state_next.flags_three[`PIRQ_B_SERIAL_B_RX] = serial_b_rx_full_i;
        state_next.flags_three[`PIRQ_B_SERIAL_B_TX] = serial_b_tx_empty_i;

        if (wr_en_one) begin
            state_next.en_one = reg_wdata_i;
        end
        if (wr_en_two) begin
            state_next.en_two = reg_wdata_i & `PIRQ_MASK_TWO;
        end
        if (wr_ctrl) begin
            state_next.ctrl = 2'(reg_wdata_i & `PIRQ_MASK_CTRL);
        end

        // Read data stands only in the cycle after the strobe
        state_next.rd_data = 8'h00;
        if (reg_rd_i) begin
            unique case (addr_idx)
                `PIRQ_OFF_FLAGS_TWO:   state_next.rd_data = state_reg.flags_two;
                `PIRQ_OFF_FLAGS_THREE: state_next.rd_data = state_reg.flags_three;
                `PIRQ_OFF_ENABLES_ONE: state_next.rd_data = state_reg.en_one;
                `PIRQ_OFF_ENABLES_TWO: state_next.rd_data = state_reg.en_two;
                `PIRQ_OFF_CONTROL:     state_next.rd_data = {6'h00, state_reg.ctrl};
                default:               state_next.rd_data = 8'h00;
            endcase
        end

        state_next.irq = any_req & gate_open;
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_reg.flags_two   <= `PIRQ_RST_BYTE;
            state_reg.flags_three <= `PIRQ_RST_BYTE;
            state_reg.en_one      <= `PIRQ_RST_BYTE;
            state_reg.en_two      <= `PIRQ_RST_BYTE;
            state_reg.ctrl        <= `PIRQ_RST_CTRL;
            state_reg.rd_data     <= `PIRQ_RST_BYTE;
            state_reg.irq         <= 1'b0;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_o      = state_reg.rd_data;
    assign peripheral_irq_o = state_reg.irq;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_osc_fail_set;
        @(posedge clock_i) disable iff (sys_rst_i)
        (ce_i && osc_fail_evt_i) |=> state_reg.flags_two[`PIRQ_B_OSC_FAIL];
    endproperty
    a_osc_fail_set: assert property (p_osc_fail_set) else $error("oscillator fail flag not set");

    property p_cmp_change_set;
        @(posedge clock_i) disable iff (sys_rst_i)
        (ce_i && $changed(u_cmp_edge.state_reg.sync_q2) && !$past(sys_rst_i)) ##1 ce_i
        |=> state_reg.flags_two[`PIRQ_B_CMP_CHANGE];
    endproperty
    a_cmp_change_set: assert property (p_cmp_change_set) else $error("comparator change flag not set");

    property p_unimpl_zero;
        @(posedge clock_i) disable iff (sys_rst_i)
        ce_i |=> (state_reg.flags_two[`PIRQ_B_TWO_UNIMPL] == 1'b0) &&
                 (state_reg.en_two[`PIRQ_B_TWO_UNIMPL] == 1'b0);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit five became set");

    property p_nvm_set;
        @(posedge clock_i) disable iff (sys_rst_i)
        (ce_i && nvm_write_done_evt_i) |=> state_reg.flags_two[`PIRQ_B_NVM_DONE];
    endproperty
    a_nvm_set: assert property (p_nvm_set) else $error("write done flag not set");

    property p_flag_hold;
        @(posedge clock_i) disable iff (sys_rst_i)
        (state_reg.flags_two[`PIRQ_B_VOLTAGE] && !(ce_i && wr_two && !reg_wdata_i[`PIRQ_B_VOLTAGE]))
        |=> state_reg.flags_two[`PIRQ_B_VOLTAGE];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("voltage flag dropped without a clear");

    property p_set_beats_clear;
        @(posedge clock_i) disable iff (sys_rst_i)
        (ce_i && wr_three && !reg_wdata_i[`PIRQ_B_TIMER4_MATCH] && timer4_match_evt_i)
        |=> state_reg.flags_three[`PIRQ_B_TIMER4_MATCH];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat a match event");

    property p_pwm_ignored;
        @(posedge clock_i) disable iff (sys_rst_i)
        (ce_i && !state_reg.flags_two[`PIRQ_B_CAPCOMP_B] && capcomp_pwm_mode_i[0] &&
         !(wr_two && reg_wdata_i[`PIRQ_B_CAPCOMP_B]))
        |=> !state_reg.flags_two[`PIRQ_B_CAPCOMP_B];
    endproperty
    a_pwm_ignored: assert property (p_pwm_ignored) else $error("capture flag set in PWM mode");

    property p_cc_three_set;
        @(posedge clock_i) disable iff (sys_rst_i)
        (ce_i && capcomp_evt_i[3] && !capcomp_pwm_mode_i[3])
        |=> state_reg.flags_three[`PIRQ_B_CAPCOMP_E];
    endproperty
    a_cc_three_set: assert property (p_cc_three_set) else $error("unit E capture flag not set");

    property p_rx_mirror;
        @(posedge clock_i) disable iff (sys_rst_i)
        ce_i |=> state_reg.flags_three[`PIRQ_B_SERIAL_B_RX] == $past(serial_b_rx_full_i);
    endproperty
    a_rx_mirror: assert property (p_rx_mirror) else $error("receive flag does not follow buffer");

    property p_tx_mirror;
        @(posedge clock_i) disable iff (sys_rst_i)
        ce_i |=> state_reg.flags_three[`PIRQ_B_SERIAL_B_TX] == $past(serial_b_tx_empty_i);
    endproperty
    a_tx_mirror: assert property (p_tx_mirror) else $error("transmit flag does not follow buffer");

    property p_global_gate;
        @(posedge clock_i) disable iff (sys_rst_i)
        (ce_i && state_reg.ctrl == 2'h0) |=> !peripheral_irq_o;
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("request raised with gates closed");

    property p_enabled_request;
        @(posedge clock_i) disable iff (sys_rst_i)
        (ce_i && state_reg.ctrl[`PIRQ_B_PERIPH_GLOBAL] &&
         (state_reg.flags_two[`PIRQ_B_TIMER3_OVF] && state_reg.en_two[`PIRQ_B_TIMER3_OVF]))
        |=> peripheral_irq_o;
    endproperty
    a_enabled_request: assert property (p_enabled_request) else $error("enabled flag raised no request");

    property p_disabled_one;
        @(posedge clock_i) disable iff (sys_rst_i)
        (ce_i && state_reg.en_one == 8'h00 && state_reg.en_two == 8'h00 && enables_three_i == 8'h00)
        |=> !peripheral_irq_o;
    endproperty
    a_disabled_one: assert property (p_disabled_one) else $error("request with every enable clear");

    property p_poll_without_enable;
        @(posedge clock_i) disable iff (sys_rst_i)
        (ce_i && sync_serial_b_evt_i && !state_reg.ctrl[`PIRQ_B_PERIPH_GLOBAL])
        |=> state_reg.flags_three[`PIRQ_B_SYNC_SERIAL_B];
    endproperty
    a_poll_without_enable: assert property (p_poll_without_enable) else $error("flag blocked by enable");

endmodule

// *** bench/pirq_periph_model.sv ***
// Behavioural peripheral side: event pulses and serial buffer levels
`timescale 1ns/1ps
module pirq_periph_model (
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        fire_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [1:0]  buf_cmd_i,
    output logic      [11:0] pulse_o,
    output logic             rx_full_o,
    output logic             tx_empty_o
);
    logic [2:0] tx_cnt_reg;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pulse_o    <= 12'h000;
            rx_full_o  <= 1'b0;
            tx_empty_o <= 1'b1;
            tx_cnt_reg <= 3'h0;
        end else begin
            // Single-cycle pulses, so a set flag proves capture, not a held level
            pulse_o <= fire_i ? (12'h001 << sel_i) : 12'h000;
            if (buf_cmd_i == 2'h1) begin
                rx_full_o <= 1'b1;
            end else if (buf_cmd_i == 2'h2) begin
                rx_full_o <= 1'b0;
            end
            if (buf_cmd_i == 2'h3) begin
                tx_empty_o <= 1'b0;
                tx_cnt_reg <= 3'h7;
            end else if (tx_cnt_reg != 3'h0) begin
                tx_cnt_reg <= tx_cnt_reg - 3'h1;
                if (tx_cnt_reg == 3'h1) begin
                    tx_empty_o <= 1'b1;
                end
            end
        end
    end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the peripheral flag and enable bank
`timescale 1ns/1ps
module tb;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        ce = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic        cmp_lvl = 1'b0;
    logic [3:0]  pwm = 4'h0;
    logic [7:0]  flags_one = 8'h00;
    logic [7:0]  en_three = 8'h00;
    logic        fire = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [1:0]  buf_cmd = 2'h0;
    logic [11:0] pulse;
    logic        rx_full;
    logic        tx_empty;
    logic        irq;
    int          n_mismatch = 0;
    int          checked = 0;
    logic [7:0]  v;
    // Register index and bit set by each model pulse
    logic [3:0]  f_reg [12] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h0, 4'h1, 4'h1, 4'h1};
    int          f_bit [12] = '{7, 4, 3, 2, 1, 7, 6, 3, 0, 0, 1, 2};

    always #10 clock_i = ~clock_i;

    pirq_bank #(.ADDR_W(4)) dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .osc_fail_evt_i(pulse[0]), .comparator_level_i(cmp_lvl), .nvm_write_done_evt_i(pulse[1]),
        .bus_collision_a_evt_i(pulse[2]), .voltage_low_evt_i(pulse[3]), .timer3_overflow_evt_i(pulse[4]),
        .sync_serial_b_evt_i(pulse[5]), .bus_collision_b_evt_i(pulse[6]), .serial_b_rx_full_i(rx_full),
        .serial_b_tx_empty_i(tx_empty), .timer4_match_evt_i(pulse[7]), .capcomp_evt_i(pulse[11:8]),
        .capcomp_pwm_mode_i(pwm), .flags_one_i(flags_one), .enables_three_i(en_three),
        .peripheral_irq_o(irq));
    pirq_periph_model model_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .fire_i(fire), .sel_i(sel),
        .buf_cmd_i(buf_cmd), .pulse_o(pulse), .rx_full_o(rx_full), .tx_empty_o(tx_empty));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_i);
        rd <= 1'b0;
        @(negedge clock_i);
        d = rdata;
    endtask
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        chk(what, d, exp);
        // Read data must drop back to zero once its single cycle is over
        @(negedge clock_i);
        chk("rdata idle", rdata, 8'h00);
    endtask
    task automatic pulse_evt(input int i);
        @(posedge clock_i);
        fire <= 1'b1;
        sel <= i[3:0];
        @(posedge clock_i);
        fire <= 1'b0;
        repeat (2) @(posedge clock_i);
    endtask
    task automatic buf_op(input logic [1:0] c);
        @(posedge clock_i);
        buf_cmd <= c;
        @(posedge clock_i);
        buf_cmd <= 2'h0;
    endtask
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        chk("irq", {7'h00, irq}, {7'h00, exp});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd_chk("flags_two", 4'h0, 8'h00);
        rd_chk("flags_three", 4'h1, 8'h10);
        rd_chk("enables_one", 4'h2, 8'h00);
        rd_chk("enables_two", 4'h3, 8'h00);
        wr_reg(4'h3, 8'hff);
        rd_chk("enables_two", 4'h3, 8'hdf);
        wr_reg(4'h2, 8'hff);
        rd_chk("enables_one", 4'h2, 8'hff);
        wr_reg(4'h0, 8'hff);
        rd_chk("flags_two", 4'h0, 8'hdf);
        wr_reg(4'h1, 8'hff);
        rd_chk("flags_three", 4'h1, 8'hdf);
        wr_reg(4'h4, 8'hff);
        rd_chk("control", 4'h4, 8'h03);
        wr_reg(4'h7, 8'hff);
        rd_chk("unmapped", 4'h7, 8'h00);
        for (int a = 0; a < 5; a++) wr_reg(a[3:0], 8'h00);
        // Every model pulse source sets its flag with all enables off, and holds it
        for (int i = 0; i < 12; i++) begin
            pulse_evt(i);
            rd_reg(f_reg[i], v);
            chk("flag", v, (f_reg[i] == 4'h1 ? 8'h10 : 8'h00) | (8'h01 << f_bit[i]));
            wr_reg(f_reg[i], 8'h00);
            rd_chk("cleared", f_reg[i], f_reg[i] == 4'h1 ? 8'h10 : 8'h00);
        end
        irq_chk(1'b0);
        @(posedge clock_i);
        pwm <= 4'hf;
        for (int i = 8; i < 12; i++) pulse_evt(i);
        rd_chk("pwm two", 4'h0, 8'h00);
        rd_chk("pwm three", 4'h1, 8'h10);
        @(posedge clock_i);
        pwm <= 4'h0;
        cmp_lvl <= 1'b1;
        flags_one <= 8'h04;
        v = 8'h00;
        for (int k = 0; k < 8 && v !== 8'h40; k++) rd_reg(4'h0, v);
        chk("comparator", v, 8'h40);
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h3, 8'h02);
        pulse_evt(4);
        irq_chk(1'b0);
        wr_reg(4'h4, 8'h01);
        irq_chk(1'b1);
        wr_reg(4'h4, 8'h02);
        irq_chk(1'b1);
        wr_reg(4'h3, 8'h00);
        irq_chk(1'b0);
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h2, 8'h04);
        irq_chk(1'b1);
        wr_reg(4'h2, 8'h00);
        buf_op(2'h1);
        rd_chk("rx full", 4'h1, 8'h30);
        @(posedge clock_i);
        en_three <= 8'h20;
        irq_chk(1'b1);
        buf_op(2'h2);
        rd_chk("rx read", 4'h1, 8'h10);
        buf_op(2'h3);
        rd_chk("tx written", 4'h1, 8'h00);
        repeat (8) @(posedge clock_i);
        rd_chk("tx drained", 4'h1, 8'h10);
        // Match event and clearing write land on the same edge: the set must win
        fork
            pulse_evt(7);
            begin
                @(posedge clock_i);
                wr_reg(4'h1, 8'h00);
            end
        join
        rd_chk("set beats clear", 4'h1, 8'h18);
        // A write while the clock enable is low must be ignored
        @(posedge clock_i);
        ce <= 1'b0;
        wr_reg(4'h2, 8'hff);
        @(posedge clock_i);
        ce <= 1'b1;
        rd_chk("frozen write", 4'h2, 8'h00);
        // Mid-run reset clears the held flags and closes the request gate
        @(posedge clock_i);
        sys_rst_i <= 1'b1;
        @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd_chk("after reset", 4'h1, 8'h10);
        irq_chk(1'b0);
        tally_and_finish();
    end
endmodule
